// ---- common/pddr_pkg.sv ----
// constants and types shared by the byte-wide port register block
// assumes a single-clock, byte-wide on-chip peripheral bus
package pddr_pkg;
  localparam int NUM_PORTS = 8;
  localparam int PORT_W = 8;
  localparam int ADDR_W = 16;
  // data latch addresses, ports 1-3 and 5-9
  localparam logic [15:0] PORT1_DATA_ADDR = 16'hFFD4;
  localparam logic [15:0] PORT2_DATA_ADDR = 16'hFFD5;
  localparam logic [15:0] PORT3_DATA_ADDR = 16'hFFD6;
  localparam logic [15:0] PORT5_DATA_ADDR = 16'hFFD8;
  localparam logic [15:0] PORT6_DATA_ADDR = 16'hFFD9;
  localparam logic [15:0] PORT7_DATA_ADDR = 16'hFFDA;
  localparam logic [15:0] PORT8_DATA_ADDR = 16'hFFDB;
  localparam logic [15:0] PORT9_DATA_ADDR = 16'hFFDC;
  // direction register addresses, same order
  localparam logic [15:0] PORT1_DIR_ADDR = 16'hFFE4;
  localparam logic [15:0] PORT2_DIR_ADDR = 16'hFFE5;
  localparam logic [15:0] PORT3_DIR_ADDR = 16'hFFE6;
  localparam logic [15:0] PORT5_DIR_ADDR = 16'hFFE8;
  localparam logic [15:0] PORT6_DIR_ADDR = 16'hFFE9;
  localparam logic [15:0] PORT7_DIR_ADDR = 16'hFFEA;
  localparam logic [15:0] PORT8_DIR_ADDR = 16'hFFEB;
  localparam logic [15:0] PORT9_DIR_ADDR = 16'hFFEC;
  // read value of a write-only direction register
  localparam logic [7:0] DIR_READ_VALUE = 8'hFF;
  // reset values, not documented: all inputs, latches clear
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [2:0] PORT_IDX_ZERO = 3'h0;

  // one byte bus request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pddr_bus_req_s;

  // result of decoding an address
  typedef struct packed {
    logic hit_data;
    logic hit_dir;
    logic [2:0] idx;
  } pddr_decode_s;
endpackage : pddr_pkg

// ---- rtl/pddr_port_regs.sv ----
// byte-wide port data latches and direction registers for eight ports
// assumes the core issues byte accesses only, one per clock at most
//
// Overview of operation
// - data read returns sampled pin level for input pins.
// - data read returns latch value for output pins.
// - direction registers are write-only; reads return all ones.
// - direction one drives pin from latch; zero turns driver off.
// - output pin drives high for latch one, low for zero.
// - data write loads all eight latch bits, inputs included.
// - data registers at consecutive byte addresses, ports 1-3, one unused slot, then 5-9.
// - byte accesses only on the 8-bit peripheral bus.
`timescale 1ns/100ps
module pddr_port_regs #(
  parameter int NUM_PORTS = pddr_pkg::NUM_PORTS,
  parameter int PORT_W = pddr_pkg::PORT_W
) (
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic CLK_EN_I,
  input wire logic BUS_RD_I,
  input wire logic BUS_WR_I,
  input wire logic [15:0] BUS_ADDR_I,
  input wire logic [7:0] BUS_WDATA_I,
  output logic [7:0] BUS_RDATA_O,
  output logic BUS_RVALID_O,
  input wire logic [NUM_PORTS*PORT_W-1:0] PIN_I,
  output logic [NUM_PORTS*PORT_W-1:0] PIN_O,
  output logic [NUM_PORTS*PORT_W-1:0] PIN_OE_O
);

  // address decode, shared by read and write paths
  // the slot of the missing fourth port decodes to nothing
  function automatic pddr_pkg::pddr_decode_s decode(input logic [15:0] a);
    pddr_pkg::pddr_decode_s d;
    d = '0;
    if (a == pddr_pkg::PORT1_DATA_ADDR) begin
      d.hit_data = 1'b1;
      d.idx = 3'h0;
    end else if (a == pddr_pkg::PORT2_DATA_ADDR) begin
      d.hit_data = 1'b1;
      d.idx = 3'h1;
    end else if (a == pddr_pkg::PORT3_DATA_ADDR) begin
      d.hit_data = 1'b1;
      d.idx = 3'h2;
    end else if (a == pddr_pkg::PORT5_DATA_ADDR) begin
      d.hit_data = 1'b1;
      d.idx = 3'h3;
    end else if (a == pddr_pkg::PORT6_DATA_ADDR) begin
      d.hit_data = 1'b1;
      d.idx = 3'h4;
    end else if (a == pddr_pkg::PORT7_DATA_ADDR) begin
      d.hit_data = 1'b1;
      d.idx = 3'h5;
    end else if (a == pddr_pkg::PORT8_DATA_ADDR) begin
      d.hit_data = 1'b1;
      d.idx = 3'h6;
    end else if (a == pddr_pkg::PORT9_DATA_ADDR) begin
      d.hit_data = 1'b1;
      d.idx = 3'h7;
    end else if (a == pddr_pkg::PORT1_DIR_ADDR) begin
      d.hit_dir = 1'b1;
      d.idx = 3'h0;
    end else if (a == pddr_pkg::PORT2_DIR_ADDR) begin
      d.hit_dir = 1'b1;
      d.idx = 3'h1;
    end else if (a == pddr_pkg::PORT3_DIR_ADDR) begin
      d.hit_dir = 1'b1;
      d.idx = 3'h2;
    end else if (a == pddr_pkg::PORT5_DIR_ADDR) begin
      d.hit_dir = 1'b1;
      d.idx = 3'h3;
    end else if (a == pddr_pkg::PORT6_DIR_ADDR) begin
      d.hit_dir = 1'b1;
      d.idx = 3'h4;
    end else if (a == pddr_pkg::PORT7_DIR_ADDR) begin
      d.hit_dir = 1'b1;
      d.idx = 3'h5;
    end else if (a == pddr_pkg::PORT8_DIR_ADDR) begin
      d.hit_dir = 1'b1;
      d.idx = 3'h6;
    end else if (a == pddr_pkg::PORT9_DIR_ADDR) begin
      d.hit_dir = 1'b1;
      d.idx = 3'h7;
    end
    return d;
  endfunction : decode

  pddr_pkg::pddr_bus_req_s req;
  pddr_pkg::pddr_decode_s dec;
  logic [PORT_W-1:0] data_latch [NUM_PORTS];
  logic [PORT_W-1:0] dir_reg [NUM_PORTS];
  logic [PORT_W-1:0] next_data_latch [NUM_PORTS];
  logic [PORT_W-1:0] next_dir_reg [NUM_PORTS];
  logic [NUM_PORTS*PORT_W-1:0] pin_meta;
  logic [NUM_PORTS*PORT_W-1:0] pin_sync;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic [NUM_PORTS*PORT_W-1:0] next_pin;
  logic [NUM_PORTS*PORT_W-1:0] next_pin_oe;

  // bundle the bus request
  assign req = '{rd: BUS_RD_I, wr: BUS_WR_I, addr: BUS_ADDR_I, wdata: BUS_WDATA_I};
  assign dec = decode(req.addr);

  // pins come from outside: two flops before anything reads them
  // only pin_sync is read; pin_meta may still be settling
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else if (CLK_EN_I) begin
      pin_meta <= PIN_I;
      pin_sync <= pin_meta;
    end
  end

  // register write next-state
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      next_data_latch[p] = data_latch[p];
      next_dir_reg[p] = dir_reg[p];
    end
    if (req.wr && dec.hit_data) begin
      next_data_latch[dec.idx] = req.wdata;
    end else if (req.wr && dec.hit_dir) begin
      next_dir_reg[dec.idx] = req.wdata;
    end
  end

  // register state
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        data_latch[p] <= pddr_pkg::DATA_RESET;
        dir_reg[p] <= pddr_pkg::DIR_RESET;
      end
    end else if (CLK_EN_I) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        data_latch[p] <= next_data_latch[p];
        dir_reg[p] <= next_dir_reg[p];
      end
    end
  end

  // read data: mix of pins and latches; read-modify-write of inputs
  // therefore copies pin levels into the latch, software must shadow
  always_comb begin
    next_rdata = pddr_pkg::UNMAPPED_READ;
    next_rvalid = req.rd;
    if (req.rd && dec.hit_data) begin
      next_rdata = (dir_reg[dec.idx] & data_latch[dec.idx])
                 | (~dir_reg[dec.idx] & pin_sync[dec.idx*PORT_W +: PORT_W]);
    end else if (req.rd && dec.hit_dir) begin
      next_rdata = pddr_pkg::DIR_READ_VALUE;
    end
  end

  // pin drive: registered so the outputs come straight from flops
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      next_pin[p*PORT_W +: PORT_W] = next_data_latch[p];
      next_pin_oe[p*PORT_W +: PORT_W] = next_dir_reg[p];
    end
  end

  // output registers; bus is byte wide so no word path exists
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      BUS_RDATA_O <= pddr_pkg::UNMAPPED_READ;
      BUS_RVALID_O <= 1'b0;
      // same reset values as the latches, so pins always mirror them
      PIN_O <= {NUM_PORTS{pddr_pkg::DATA_RESET}};
      PIN_OE_O <= {NUM_PORTS{pddr_pkg::DIR_RESET}};
    end else if (CLK_EN_I) begin
      BUS_RDATA_O <= next_rdata;
      BUS_RVALID_O <= next_rvalid;
      PIN_O <= next_pin;
      PIN_OE_O <= next_pin_oe;
    end
  end

  // checks on observable behaviour
  // internal state is used as reference, including latch and direction state that PIN_O and PIN_OE_O also show
  // direction read check
  property p_dir_read_ones;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CLK_EN_I && req.rd && dec.hit_dir) |=> (BUS_RDATA_O == pddr_pkg::DIR_READ_VALUE);
  endproperty
  a_dir_read_ones: assert property (p_dir_read_ones) else $error("dir read not ones");

  property p_out_read_latch;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CLK_EN_I && req.rd && dec.hit_data) |=>
      ((BUS_RDATA_O & $past(dir_reg[dec.idx])) == ($past(data_latch[dec.idx])
        & $past(dir_reg[dec.idx])));
  endproperty
  a_out_read_latch: assert property (p_out_read_latch) else $error("output bit misread");

  property p_in_read_pin;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CLK_EN_I && req.rd && dec.hit_data) |=>
      ((BUS_RDATA_O & ~$past(dir_reg[dec.idx])) ==
       ($past(pin_sync[dec.idx*PORT_W +: PORT_W]) & ~$past(dir_reg[dec.idx])));
  endproperty
  a_in_read_pin: assert property (p_in_read_pin) else $error("input bit misread");

  sequence s_data_write;
    CLK_EN_I && req.wr && dec.hit_data;
  endsequence
  property p_write_whole;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    s_data_write |=> (data_latch[$past(dec.idx)] == $past(req.wdata));
  endproperty
  a_write_whole: assert property (p_write_whole) else $error("latch not loaded");

  property p_pin_drive;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    s_data_write |=> (PIN_O[$past(dec.idx)*PORT_W +: PORT_W] == $past(req.wdata));
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin not from latch");

  property p_oe_dir;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CLK_EN_I && req.wr && dec.hit_dir) |=>
      (PIN_OE_O[$past(dec.idx)*PORT_W +: PORT_W] == $past(req.wdata));
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("driver enable wrong");

  property p_port3_addr;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (req.addr == pddr_pkg::PORT3_DATA_ADDR) |-> (dec.hit_data && dec.idx == 3'h2);
  endproperty
  a_port3_addr: assert property (p_port3_addr) else $error("port 3 decode wrong");

  property p_rvalid;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CLK_EN_I && req.rd) |=> BUS_RVALID_O;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");

  property p_rvalid_idle;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CLK_EN_I && !req.rd) |=> !BUS_RVALID_O;
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle) else $error("answer without read");

  sequence s_stray_read;
    CLK_EN_I && req.rd && !dec.hit_data && !dec.hit_dir;
  endsequence
  property p_unmapped_read;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    s_stray_read |=> (BUS_RDATA_O == pddr_pkg::UNMAPPED_READ);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("stray read not zero");

  // frozen pins hold
  // a gated enable must not glitch the pins, whatever the bus does
  property p_frozen_pins;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    !CLK_EN_I |=> ($stable(PIN_O) && $stable(PIN_OE_O));
  endproperty
  a_frozen_pins: assert property (p_frozen_pins) else $error("pins moved while frozen");

  property p_dir_write_keeps_pins;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CLK_EN_I && req.wr && dec.hit_dir) |=> $stable(PIN_O);
  endproperty
  a_dir_write_keeps_pins: assert property (p_dir_write_keeps_pins) else $error("level moved");

  property p_data_write_keeps_oe;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    s_data_write |=> $stable(PIN_OE_O);
  endproperty
  a_data_write_keeps_oe: assert property (p_data_write_keeps_oe) else $error("enable moved");

  // only writes load latches
  // a read alone must never copy pin levels into the latch
  sequence s_data_read;
    CLK_EN_I && req.rd && dec.hit_data;
  endsequence
  property p_read_keeps_latch;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    s_data_read |=> (data_latch[$past(dec.idx)] == $past(data_latch[dec.idx]));
  endproperty
  a_read_keeps_latch: assert property (p_read_keeps_latch) else $error("read changed latch");

endmodule : pddr_port_regs

// ---- verification/pddr_pin_board.sv ----
// board model behind the port pins
// assumes board drivers on every pin; a driving port wins
`timescale 1ns/100ps
module pddr_pin_board (
  input wire logic [63:0] drv_i,
  input wire logic [63:0] oe_i,
  input wire logic [63:0] ext_i,
  output logic [63:0] level_o
);
  // weak board level, overridden where the port drives
  assign level_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule : pddr_pin_board

// ---- verification/pddr_port_regs_tb_top.sv ----
// self-checking bench for the port register block
// assumes byte accesses, read answer within a few cycles
`timescale 1ns/100ps
module pddr_port_regs_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic rvalid;
  logic [63:0] pin_in;
  logic [63:0] pout;
  logic [63:0] poe;
  logic [63:0] board = 64'h0;
  logic [7:0] dir_m [8];
  logic [7:0] lat_m [8];
  logic [63:0] e_oe;
  logic [7:0] got;
  integer seed = 76;
  int failures = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  pddr_port_regs u_dut (.CLOCK_I(clk), .SYS_RST_I(rst), .CLK_EN_I(en), .BUS_RD_I(rd),
    .BUS_WR_I(wr), .BUS_ADDR_I(addr), .BUS_WDATA_I(wdata), .BUS_RDATA_O(rdata),
    .BUS_RVALID_O(rvalid), .PIN_I(pin_in), .PIN_O(pout), .PIN_OE_O(poe));
  pddr_pin_board u_board (.drv_i(pout), .oe_i(poe), .ext_i(board), .level_o(pin_in));
  // port 4 has no address, so ports 5-9 skip one slot
  function automatic logic [15:0] padr(input int i, input logic [15:0] base);
    return base + 16'(i) + ((i > 2) ? 16'h0001 : 16'h0000);
  endfunction : padr
  function automatic logic [7:0] exp_rd(input int i);
    return (dir_m[i] & lat_m[i]) | (~dir_m[i] & board[8*i+:8]);
  endfunction : exp_rd
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic chk8(input string w, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask : chk8
  task automatic chk64(input string w, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask : chk64
  // single byte write, one idle edge before
  task automatic bwr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bwr
  task automatic brd(input logic [15:0] a, output logic [7:0] d);
    int n;
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    n = 0;
    #1;
    while (rvalid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (rvalid !== 1'b1) begin
      failures++;
      $display("Error read answer expected 1 seen %b", rvalid);
      tally_and_finish();
    end else begin
      d = rdata;
    end
  endtask : brd
  task automatic set_board(input logic [63:0] v);
    @(posedge clk);
    board <= v;
    repeat (4) @(posedge clk);
  endtask : set_board
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // rounds 0 and 1 are all-input and all-output corners
    for (int r = 0; r < 6; r++) begin
      for (int i = 0; i < 8; i++) begin
        dir_m[i] = (r == 0) ? 8'h00 : (r == 1) ? 8'hFF : 8'($random(seed));
        lat_m[i] = 8'($random(seed));
        bwr(padr(i, pddr_pkg::PORT1_DATA_ADDR), lat_m[i]);
        bwr(padr(i, pddr_pkg::PORT1_DIR_ADDR), dir_m[i]);
        e_oe[8*i+:8] = dir_m[i];
      end
      set_board({32'($random(seed)), 32'($random(seed))});
      chk64("pin enables", e_oe, poe);
      chk64("pin levels", e_oe & {lat_m[7], lat_m[6], lat_m[5], lat_m[4], lat_m[3],
        lat_m[2], lat_m[1], lat_m[0]}, e_oe & pout);
      for (int i = 0; i < 8; i++) begin
        brd(padr(i, pddr_pkg::PORT1_DATA_ADDR), got);
        chk8("data read", exp_rd(i), got);
        brd(padr(i, pddr_pkg::PORT1_DIR_ADDR), got);
        chk8("direction read", 8'hFF, got);
      end
    end
    // read-modify-write on port 3 picks up input levels
    bwr(pddr_pkg::PORT3_DIR_ADDR, 8'h3F);
    bwr(pddr_pkg::PORT3_DATA_ADDR, 8'h80);
    set_board(64'h0000_0000_0040_0000);
    brd(pddr_pkg::PORT3_DATA_ADDR, got);
    chk8("port3 read", 8'h40, got);
    bwr(pddr_pkg::PORT3_DATA_ADDR, got | 8'h01);
    @(posedge clk);
    chk8("port3 latch", 8'h41, pout[23:16]);
    // shadow copy writes keep the intended bits
    bwr(pddr_pkg::PORT3_DATA_ADDR, 8'h81);
    bwr(pddr_pkg::PORT3_DIR_ADDR, 8'h3E);
    @(posedge clk);
    chk8("port3 shadow latch", 8'h81, pout[23:16]);
    chk8("port3 shadow dir", 8'h3E, poe[23:16]);
    // unmapped slots: no effect, zero data
    bwr(16'hFFD7, 8'hFF);
    bwr(16'hFFE7, 8'hFF);
    brd(16'hFFD7, got);
    chk8("unmapped read", pddr_pkg::UNMAPPED_READ, got);
    chk8("port3 after stray", 8'h3E, poe[23:16]);
    chk8("port3 latch after stray", 8'h81, pout[23:16]);
    // frozen clock enable: the write is not taken, pins hold
    @(posedge clk);
    en <= 1'b0;
    bwr(pddr_pkg::PORT3_DATA_ADDR, 8'h00);
    en <= 1'b1;
    @(posedge clk);
    chk8("frozen latch", 8'h81, pout[23:16]);
    // second reset in mid-run, then a first write right after it
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk64("reset enables", {8{pddr_pkg::DIR_RESET}}, poe);
    chk64("reset levels", {8{pddr_pkg::DATA_RESET}}, pout);
    bwr(pddr_pkg::PORT1_DATA_ADDR, 8'h5A);
    @(posedge clk);
    chk8("port1 after reset", 8'h5A, pout[7:0]);
    tally_and_finish();
  end
endmodule : pddr_port_regs_tb_top
